// >>> common/pacfg_pkg.sv
// Package with offsets, field positions, reset values and strap codes of the register bank.
package pacfg_pkg;
    // ****************************************************************
    // Register offsets (5-bit management register index).
    // ****************************************************************
    localparam logic [4:0] ADDR_ADVERT     = 5'h04;
    localparam logic [4:0] ADDR_PARTNER    = 5'h05;
    localparam logic [4:0] ADDR_EXPANSION  = 5'h06;
    localparam logic [4:0] ADDR_LOCAL_NP   = 5'h07;
    localparam logic [4:0] ADDR_PARTNER_NP = 5'h08;
    localparam logic [4:0] ADDR_PLL_CTRL   = 5'h10;
    localparam logic [4:0] ADDR_AFE_CTRL   = 5'h11;
    localparam logic [4:0] ADDR_SYM_ERR    = 5'h15;
    localparam logic [4:0] ADDR_STRAP_OVR  = 5'h16;
    localparam logic [4:0] ADDR_STRAP_STAT = 5'h17;
    localparam logic [4:0] ADDR_EXP_CTRL   = 5'h18;
    localparam logic [4:0] ADDR_INT_CTRL   = 5'h1B;
    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int ADV_NEXT_PAGE  = 15;
    localparam int ADV_REM_FAULT  = 13;
    localparam int ADV_PAUSE_LO   = 10;
    localparam int ADV_T4         = 9;
    localparam int ADV_TX_FD      = 8;
    localparam int ADV_TX_HD      = 7;
    localparam int ADV_10_FD      = 6;
    localparam int ADV_10_HD      = 5;
    localparam int PA_ACK         = 14;
    localparam int EXP_PD_FAULT   = 4;
    localparam int EXP_LP_NP_ABLE = 3;
    localparam int EXP_NP_ABLE    = 2;
    localparam int EXP_PAGE_RX    = 1;
    localparam int EXP_LP_AN_ABLE = 0;
    localparam int NP_MORE        = 15;
    localparam int NP_MSG_PAGE    = 13;
    localparam int NP_COMPLY_ACK  = 12;
    localparam int NP_TOGGLE      = 11;
    localparam int PLL_OFF_BIT    = 4;
    localparam int AFE_SLOW_OSC   = 5;
    localparam int OVR_FACTORY    = 15;
    localparam int OVR_BCAST_OFF  = 9;
    localparam int OVR_B2B        = 6;
    localparam int OVR_NAND       = 5;
    localparam int OVR_RMII       = 1;
    localparam int STAT_ADDR_LO   = 13;
    localparam int STAT_RMII      = 1;
    localparam int EXP_SLEEP_DIS  = 11;
    localparam int INT_EN_LO      = 8;
    // ****************************************************************
    // Reset values and codes.
    // ****************************************************************
    localparam logic [4:0]  SELECTOR_8023  = 5'h01;
    localparam logic [1:0]  PAUSE_RESET    = 2'h0;
    localparam logic [10:0] NP_MSG_RESET   = 11'h001;
    localparam logic [15:0] SYM_ERR_RESET  = 16'h0000;
    localparam logic [2:0]  MGMT_ADDR_0    = 3'h0;
    localparam logic [2:0]  MGMT_ADDR_3    = 3'h3;
endpackage

// >>> hw/pacfg_regs.sv
// Auto-negotiation and power-saving management register bank.
`timescale 1ns/1ps
// Summary of operation
// - Pause field: 00 none, 10 asym, 01 sym, 11 both; writable, resets 00.
// - 100TX full/half advertisement reset from latched speed strap, writable.
// - 10T full/half advertisement reset to 1, writable; T4 bit reads 0.
// - Selector field reads 00001 in local and partner registers.
// - Partner ability read-only, shows base page, ack once code word received.
// - Parallel detection fault flag latches high, read-only.
// - Page received flag latches high on every new page.
// - Expansion shows local next-page able 1, partner next-page and AN able.
// - Transmit next page: more, message page (reset 1), comply_ack, message 1.
// - Transmit toggle bit shows toggle of previous transmitted code word.
// - Partner next page read-only, reset 0; toggle is inverse of sent toggle.
// - PLL-off bit switches PLL off in energy-detect power-down, else stays on.
// - Energy-detect power-down disable resets to 1; writing 0 enables it.
// - Slow oscillator bit drops reference clock, selects slow osc, powers down.
// - Sixteen-bit symbol error frame counter, resets zero, clears on read.
// - Factory mode loads receive-error pin at reset release; software writes 0.
// - Broadcast-off bit stops address 0 acting as broadcast.
// - NAND-tree override bit forces NAND-tree mode regardless of strap.
// - Read-only strapped address field: 000 or 011 only.
// - Strap status bit reads 1 when reduced interface mode was strapped.
// - Interrupt upper byte: eight enables reset 0; jabber status clears on read.
// - Self-cleared bits clear when consumed; latched-high bits hold until read.
// - Lower status bits report eight events, each clears on read, reset 0.
module pacfg_regs
    import pacfg_pkg::*;
(
    input  wire logic        clk,                  // 10 MHz bank clock.
    input  wire logic        reset_n,              // Async reset, active low.
    input  wire logic        reg_wr,               // Register write strobe.
    input  wire logic        reg_rd,               // Register read strobe.
    input  wire logic [4:0]  reg_addr,             // Register index.
    input  wire logic [15:0] reg_wdata,            // Write data.
    output logic      [15:0] reg_rdata,            // Read data, valid cycle after reg_rd.
    input  wire logic        autoneg_speed_strap,  // Speed strap level.
    input  wire logic        receive_error_pin,    // Receive-error pin pull level.
    input  wire logic        broadcast_off_strap,  // Broadcast-off strap level.
    input  wire logic [2:0]  mgmt_address_strap,   // Management address strap.
    input  wire logic        rmii_strap,           // Reduced interface strap level.
    input  wire logic        nand_tree_strap,      // NAND-tree strap level.
    input  wire logic        page_rx,              // Pulse: base or next page arrived.
    input  wire logic [15:0] page_word,            // Received link code word.
    input  wire logic        page_is_next,         // Received page is a next page.
    input  wire logic        partner_an_able,      // Partner can auto-negotiate.
    input  wire logic        pd_fault,             // Pulse: parallel detection fault.
    input  wire logic        tx_page_done,         // Pulse: local code word sent.
    input  wire logic        tx_toggle,            // Toggle of the word just sent.
    input  wire logic        symbol_err_frame,     // Pulse: frame with symbol error.
    input  wire logic        energy_present,       // Energy seen on receive pair.
    input  wire logic [7:0]  event_in,             // Pulses: jabber..link-up order.
    output logic             pll_off,              // PLL shut down.
    output logic             energy_detect_power_down, // Energy-detect power-down active.
    output logic             slow_osc_sel,         // Slow oscillator selected.
    output logic             ref_clk_disconnect,   // Reference clock input cut off.
    output logic             analog_power_down,    // Analog side powered down.
    output logic             factory_mode,         // Factory test mode active.
    output logic             broadcast_enable,     // Address 0 is broadcast.
    output logic             nand_tree_mode,       // NAND-tree test mode.
    output logic             back_to_back_repeater,// Back-to-back repeater mode.
    output logic             rmii_mode,            // Reduced interface mode.
    output logic [2:0]       mgmt_address,         // Latched management address.
    output logic             irq                   // Interrupt, active high.
);
    // ****************************************************************
    // Storage.
    // ****************************************************************
    logic [15:0] advert;
    logic [15:0] partner;
    logic [15:0] partner_np;
    logic [15:0] local_np;
    logic        pd_fault_lh;
    logic        page_rx_lh;
    logic        lp_np_able;
    logic        lp_an_able;
    logic        pll_off_en;
    logic        slow_osc;
    logic [15:0] sym_err;
    logic [15:0] strap_ovr;
    logic [2:0]  addr_latch;
    logic        rmii_latch;
    logic        nand_latch;
    logic        bcast_latch;
    logic        sleep_dis;
    logic [7:0]  int_en;
    logic [7:0]  int_stat;
    logic        strap_taken;

    // ****************************************************************
    // Decode.
    // ****************************************************************
    // Write and read strobes per register.
    wire wr_adv   = reg_wr && reg_addr == ADDR_ADVERT;
    wire wr_np    = reg_wr && reg_addr == ADDR_LOCAL_NP;
    wire wr_pll   = reg_wr && reg_addr == ADDR_PLL_CTRL;
    wire wr_afe   = reg_wr && reg_addr == ADDR_AFE_CTRL;
    wire wr_ovr   = reg_wr && reg_addr == ADDR_STRAP_OVR;
    wire wr_exp   = reg_wr && reg_addr == ADDR_EXP_CTRL;
    wire wr_int   = reg_wr && reg_addr == ADDR_INT_CTRL;
    wire rd_exp   = reg_rd && reg_addr == ADDR_EXPANSION;
    wire rd_sym   = reg_rd && reg_addr == ADDR_SYM_ERR;
    wire rd_int   = reg_rd && reg_addr == ADDR_INT_CTRL;

    // Fixed and read-only fields are forced here so writes cannot alter them.
    wire [15:0] adv_view = {advert[15], 1'b0, advert[13], 1'b0, advert[11:10], 1'b0,
                            advert[8:5], SELECTOR_8023};
    wire [15:0] exp_view = {11'h000, pd_fault_lh, lp_np_able, 1'b1,
                            page_rx_lh, lp_an_able};
    wire [15:0] np_view  = {local_np[15], 1'b0, local_np[13:12], local_np[11],
                            local_np[10:0]};
    wire [15:0] stat_view = {addr_latch, 11'h000, rmii_latch, 1'b0};
    wire [15:0] int_view  = {int_en, int_stat};

    // Read multiplexer; unmapped indices read zero.
    logic [15:0] next_rdata;
    always_comb begin
        unique case (reg_addr)
            ADDR_ADVERT:     next_rdata = adv_view;
            ADDR_PARTNER:    next_rdata = partner;
            ADDR_EXPANSION:  next_rdata = exp_view;
            ADDR_LOCAL_NP:   next_rdata = np_view;
            ADDR_PARTNER_NP: next_rdata = partner_np;
            ADDR_PLL_CTRL:   next_rdata = {11'h000, pll_off_en, 4'h0};
            ADDR_AFE_CTRL:   next_rdata = {10'h000, slow_osc, 5'h00};
            ADDR_SYM_ERR:    next_rdata = sym_err;
            ADDR_STRAP_OVR:  next_rdata = strap_ovr;
            ADDR_STRAP_STAT: next_rdata = stat_view;
            ADDR_EXP_CTRL:   next_rdata = {4'h0, sleep_dis, 11'h000};
            ADDR_INT_CTRL:   next_rdata = int_view;
            default:         next_rdata = 16'h0000;
        endcase
    end

    // Strap-dependent reset values of the 100TX bits are applied once after release.
    wire [15:0] adv_strap = {advert[15:9], autoneg_speed_strap, autoneg_speed_strap, advert[6:0]};

    // ****************************************************************
    // Straps, caught by a clocked process after reset release.
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_taken <= 1'b0;
            addr_latch  <= MGMT_ADDR_0;
            rmii_latch  <= 1'b0;
            nand_latch  <= 1'b0;
            bcast_latch <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            // Only addresses 0 and 3 exist; any other strap reads as 3.
            addr_latch  <= (mgmt_address_strap == MGMT_ADDR_0) ? MGMT_ADDR_0 : MGMT_ADDR_3;
            rmii_latch  <= rmii_strap;
            nand_latch  <= nand_tree_strap;
            bcast_latch <= broadcast_off_strap;
        end
    end

    // ****************************************************************
    // Advertisement and next page registers.
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            advert <= {4'h0, PAUSE_RESET, 1'b0, 2'b00, 2'b11, SELECTOR_8023};
        end else if (!strap_taken) begin
            advert <= adv_strap;
        end else if (wr_adv) begin
            advert <= reg_wdata;
        end
    end

    // Toggle follows each sent word; host fields stay writable.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            local_np <= {3'b001, 1'b0, 1'b0, NP_MSG_RESET};
        end else begin
            if (wr_np) begin
                local_np[NP_MORE]       <= reg_wdata[NP_MORE];
                local_np[NP_MSG_PAGE]   <= reg_wdata[NP_MSG_PAGE];
                local_np[NP_COMPLY_ACK] <= reg_wdata[NP_COMPLY_ACK];
                local_np[10:0]          <= reg_wdata[10:0];
            end
            if (tx_page_done) begin
                local_np[NP_TOGGLE] <= tx_toggle;
            end
        end
    end

    // ****************************************************************
    // Received pages and expansion flags.
    // ****************************************************************
    // A set arriving in the read cycle wins, so no event is lost.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            partner     <= {11'h000, SELECTOR_8023};
            partner_np  <= 16'h0000;
            pd_fault_lh <= 1'b0;
            page_rx_lh  <= 1'b0;
            lp_np_able  <= 1'b0;
            lp_an_able  <= 1'b0;
        end else begin
            lp_an_able <= partner_an_able;
            if (page_rx && !page_is_next) begin
                partner    <= {page_word[15], 1'b1, page_word[13], 1'b0,
                               page_word[11:5], SELECTOR_8023};
                lp_np_able <= page_word[15];
            end
            if (page_rx && page_is_next) begin
                partner_np <= {page_word[15:12], ~local_np[NP_TOGGLE], page_word[10:0]};
            end
            pd_fault_lh <= pd_fault | (pd_fault_lh & ~rd_exp);
            page_rx_lh  <= page_rx  | (page_rx_lh  & ~rd_exp);
        end
    end

    // ****************************************************************
    // Power-saving and strap override controls.
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pll_off_en <= 1'b0;
            slow_osc   <= 1'b0;
            sleep_dis  <= 1'b1;
            strap_ovr  <= 16'h0002;
        end else begin
            if (wr_pll) pll_off_en <= reg_wdata[PLL_OFF_BIT];
            if (wr_afe) slow_osc   <= reg_wdata[AFE_SLOW_OSC];
            if (wr_exp) sleep_dis  <= reg_wdata[EXP_SLEEP_DIS];
            if (!strap_taken) begin
                strap_ovr[OVR_FACTORY] <= receive_error_pin;
            end else if (wr_ovr) begin
                strap_ovr <= {reg_wdata[15:11], 1'b0, reg_wdata[9:0]};
            end
        end
    end

    // ****************************************************************
    // Symbol error counter and interrupt register.
    // ****************************************************************
    // A count in the read cycle restarts the counter at one rather than being lost.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sym_err <= SYM_ERR_RESET;
        end else if (rd_sym) begin
            sym_err <= {15'h0000, symbol_err_frame};
        end else if (symbol_err_frame && sym_err != 16'hFFFF) begin
            sym_err <= sym_err + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            int_en   <= 8'h00;
            int_stat <= 8'h00;
        end else begin
            if (wr_int) int_en <= reg_wdata[15:8];
            int_stat <= event_in | (int_stat & {8{~rd_int}});
        end
    end

    // ****************************************************************
    // Registered outputs.
    // ****************************************************************
    wire sleep_now = ~sleep_dis & ~energy_present;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata             <= 16'h0000;
            pll_off               <= 1'b0;
            energy_detect_power_down <= 1'b0;
            slow_osc_sel          <= 1'b0;
            ref_clk_disconnect    <= 1'b0;
            analog_power_down     <= 1'b0;
            factory_mode          <= 1'b0;
            broadcast_enable      <= 1'b1;
            nand_tree_mode        <= 1'b0;
            back_to_back_repeater <= 1'b0;
            rmii_mode             <= 1'b0;
            mgmt_address          <= MGMT_ADDR_0;
            irq                   <= 1'b0;
        end else begin
            reg_rdata             <= next_rdata;
            energy_detect_power_down <= sleep_now;
            pll_off               <= sleep_now & pll_off_en;
            slow_osc_sel          <= slow_osc;
            ref_clk_disconnect    <= slow_osc;
            analog_power_down     <= slow_osc;
            factory_mode          <= strap_ovr[OVR_FACTORY];
            broadcast_enable      <= ~strap_ovr[OVR_BCAST_OFF] & ~bcast_latch;
            nand_tree_mode        <= strap_ovr[OVR_NAND] | nand_latch;
            back_to_back_repeater <= strap_ovr[OVR_B2B] & strap_ovr[OVR_RMII];
            rmii_mode             <= strap_ovr[OVR_RMII] | rmii_latch;
            mgmt_address          <= addr_latch;
            irq                   <= |(int_en & int_stat);
        end
    end
endmodule // pacfg_regs

// >>> tb/pacfg_regs_props.sv
// Concurrent assertions on the ports of the register bank.
`timescale 1ns/1ps
module pacfg_regs_props
    import pacfg_pkg::*;
(
    input wire logic        clk,                   // Bank clock.
    input wire logic        reset_n,               // Async reset, active low.
    input wire logic        reg_rd,                // Read strobe.
    input wire logic [4:0]  reg_addr,              // Register index.
    input wire logic [15:0] reg_rdata,             // Registered read data.
    input wire logic        page_rx,               // Page arrival pulse.
    input wire logic        pd_fault,              // Parallel fault pulse.
    input wire logic        symbol_err_frame,      // Symbol error frame pulse.
    input wire logic        energy_present,        // Energy on receive pair.
    input wire logic [7:0]  event_in,              // Interrupt event pulses.
    input wire logic        pll_off,               // PLL shut down.
    input wire logic        energy_detect_power_down, // Energy-detect power-down.
    input wire logic        slow_osc_sel,          // Slow oscillator chosen.
    input wire logic        ref_clk_disconnect,    // Reference clock cut.
    input wire logic        analog_power_down,     // Analog side down.
    input wire logic        back_to_back_repeater, // Repeater mode.
    input wire logic        rmii_mode,             // Reduced interface mode.
    input wire logic [2:0]  mgmt_address,          // Latched address.
    input wire logic        irq                    // Interrupt output.
);
    // One clock domain; a reset voids checks in flight.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    t4_zero_a: assert property ((reg_addr == ADDR_ADVERT) |=> !reg_rdata[ADV_T4])
        else $error("T4 bit reads one.");
    selector_code_a: assert property ((reg_addr == ADDR_ADVERT || reg_addr == ADDR_PARTNER)
        |=> reg_rdata[4:0] == SELECTOR_8023)
        else $error("Bad selector field.");
    np_able_a: assert property ((reg_addr == ADDR_EXPANSION) |=> reg_rdata[EXP_NP_ABLE])
        else $error("Next-page ability missing.");
    // A clean read leaves both latched flags low.
    latch_clear_a: assert property (
        (reg_rd && reg_addr == ADDR_EXPANSION && !page_rx && !pd_fault)
        ##1 (reg_addr == ADDR_EXPANSION && !page_rx && !pd_fault)
        |=> !reg_rdata[EXP_PAGE_RX] && !reg_rdata[EXP_PD_FAULT])
        else $error("Latched flag survived read.");
    count_clear_a: assert property (
        (reg_rd && reg_addr == ADDR_SYM_ERR && !symbol_err_frame)
        ##1 (reg_addr == ADDR_SYM_ERR) |=> reg_rdata == 16'h0000)
        else $error("Counter not cleared by read.");
    pll_sleep_a: assert property (pll_off |-> energy_detect_power_down)
        else $error("PLL off outside power-down.");
    sleep_energy_a: assert property (energy_detect_power_down |-> !$past(energy_present))
        else $error("Power-down with energy present.");
    slow_osc_a: assert property (slow_osc_sel |-> ref_clk_disconnect && analog_power_down)
        else $error("Slow oscillator side effects missing.");
    b2b_rmii_a: assert property (back_to_back_repeater |-> rmii_mode)
        else $error("Repeater mode without reduced mode.");
    addr_pair_a: assert property (mgmt_address == MGMT_ADDR_0 || mgmt_address == MGMT_ADDR_3)
        else $error("Unsupported management address.");
    irq_release_a: assert property (
        (reg_rd && reg_addr == ADDR_INT_CTRL && event_in == 8'h00)
        ##1 (event_in == 8'h00) |=> !irq)
        else $error("Interrupt high after read.");
    // Main scenarios seen at least once.
    irq_seen_c: cover property ($rose(irq));
    pll_seen_c: cover property (energy_detect_power_down && pll_off);
    slow_seen_c: cover property (slow_osc_sel);
endmodule // pacfg_regs_props

// >>> tb/pacfg_mgr.sv
// Management station model: register writes and reads.
`timescale 1ns/1ps
module pacfg_mgr (
    input  wire logic        clk,       // Bank clock.
    output logic             reg_wr,    // Write strobe.
    output logic             reg_rd,    // Read strobe.
    output logic      [4:0]  reg_addr,  // Register index.
    output logic      [15:0] reg_wdata, // Write data.
    input  wire logic [15:0] reg_rdata  // Read data.
);
    // Idle bus at time zero.
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h1F;
        reg_wdata = 16'h0000;
    end
    // Write data is inverted once released so a stale word never looks valid.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk) #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // Read data is taken in the cycle after the strobe edge.
    task automatic rd(input logic [4:0] a, output logic [15:0] q);
        @(posedge clk) #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk) #1;
        reg_rd = 1'b0;
        q = reg_rdata;
    endtask
endmodule // pacfg_mgr

// >>> tb/testbench.sv
// Self-checking testbench for the management register bank.
`timescale 1ns/1ps
module testbench
    import pacfg_pkg::*;
;
    logic        clk, reset_n, reg_wr, reg_rd, page_rx, page_is_next, pd_fault, tx_page_done;
    logic        tx_toggle, symbol_err_frame, energy_present, partner_an_able, irq, pll_off;
    logic        autoneg_speed_strap, receive_error_pin, broadcast_off_strap, rmii_strap;
    logic        nand_tree_strap, slow_osc_sel, ref_clk_disconnect, factory_mode;
    logic        analog_power_down, broadcast_enable, nand_tree_mode, back_to_back_repeater;
    logic        rmii_mode, energy_detect_power_down;
    logic [2:0]  mgmt_address_strap, mgmt_address;
    logic [4:0]  reg_addr;
    logic [7:0]  event_in;
    logic [15:0] reg_wdata, reg_rdata, q, page_word;
    int          err_count, cmp_count;

    pacfg_regs dut (.*);
    pacfg_mgr mgr (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);

    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_reset();
        logic [4:0]  ra [13] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h10, 5'h11,
                                 5'h15, 5'h16, 5'h17, 5'h18, 5'h1B};
        logic [15:0] rv [13] = '{16'h01E1, 16'h0001, 16'h0005, 16'h2001, 16'h0000, 16'h0000,
                                 16'h0000, 16'h0000, 16'h0000, 16'h8002, 16'h6002, 16'h0800,
                                 16'h0000};
        chk({10'h0, factory_mode, broadcast_enable, rmii_mode, mgmt_address}, 16'h003B);
        for (int i = 0; i < 13; i++) begin
            mgr.rd(ra[i], q);
            chk(q, rv[i]);
        end
    endtask
    task automatic t_advert();
        mgr.wr(ADDR_ADVERT, 16'hFFFF);
        mgr.rd(ADDR_ADVERT, q);
        chk(q, 16'hADE1);
        for (int i = 0; i < 4; i++) begin
            mgr.wr(ADDR_ADVERT, {4'h0, 2'(i), 10'h000});
            mgr.rd(ADDR_ADVERT, q);
            chk(q, {4'h0, 2'(i), 10'h001});
        end
    endtask
    // Page words are inverted once their strobe has gone.
    task automatic t_pages();
        page_word = 16'h45E1;
        page_rx = 1'b1;
        pd_fault = 1'b1;
        @(posedge clk) #1;
        page_rx = 1'b0;
        pd_fault = 1'b0;
        page_word = ~page_word;
        mgr.rd(ADDR_PARTNER, q);
        chk(q, 16'h45E1);
        mgr.rd(ADDR_EXPANSION, q);
        chk(q, 16'h0017);
        mgr.rd(ADDR_EXPANSION, q);
        chk(q, 16'h0005);
        mgr.wr(ADDR_LOCAL_NP, 16'hFFFF);
        mgr.rd(ADDR_LOCAL_NP, q);
        chk(q, 16'hB7FF);
        tx_toggle = 1'b1;
        tx_page_done = 1'b1;
        @(posedge clk) #1;
        tx_page_done = 1'b0;
        mgr.rd(ADDR_LOCAL_NP, q);
        chk(q, 16'hBFFF);
        page_word = 16'hA801;
        page_is_next = 1'b1;
        page_rx = 1'b1;
        @(posedge clk) #1;
        page_rx = 1'b0;
        page_word = ~page_word;
        mgr.rd(ADDR_PARTNER_NP, q);
        chk(q, 16'hA001);
    endtask
    task automatic t_power();
        mgr.wr(ADDR_EXP_CTRL, 16'h0000);
        mgr.wr(ADDR_PLL_CTRL, 16'h0010);
        settle();
        chk({14'h0, energy_detect_power_down, pll_off}, 16'h0003);
        energy_present = 1'b1;
        settle();
        chk({14'h0, energy_detect_power_down, pll_off}, 16'h0000);
        mgr.wr(ADDR_AFE_CTRL, 16'h0020);
        settle();
        chk({13'h0, slow_osc_sel, ref_clk_disconnect, analog_power_down}, 16'h0007);
    endtask
    task automatic t_irq();
        mgr.wr(ADDR_INT_CTRL, 16'h2000);
        event_in = 8'hA0;
        @(posedge clk) #1;
        event_in = 8'h00;
        settle();
        chk({15'h0, irq}, 16'h0001);
        mgr.rd(ADDR_INT_CTRL, q);
        chk(q, 16'h20A0);
        settle();
        chk({15'h0, irq}, 16'h0000);
    endtask
    task automatic t_misc();
        mgr.wr(ADDR_STRAP_OVR, 16'h0662);
        settle();
        chk({12'h0, factory_mode, broadcast_enable, nand_tree_mode, back_to_back_repeater},
            16'h0003);
        mgr.rd(ADDR_STRAP_OVR, q);
        chk(q, 16'h0262);
        symbol_err_frame = 1'b1;
        repeat (3) @(posedge clk);
        #1 symbol_err_frame = 1'b0;
        mgr.rd(ADDR_SYM_ERR, q);
        chk(q, 16'h0003);
        mgr.rd(ADDR_SYM_ERR, q);
        chk(q, 16'h0000);
    endtask

    // Clock at 10 MHz.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Receive-error pin is pulled high across reset and for two clocks after release.
    initial begin
        {reset_n, page_rx, page_is_next, pd_fault, tx_page_done, tx_toggle} = 6'h00;
        {symbol_err_frame, energy_present, broadcast_off_strap, nand_tree_strap} = 4'h0;
        {autoneg_speed_strap, receive_error_pin, rmii_strap, partner_an_able} = 4'hF;
        mgmt_address_strap = 3'h3;
        event_in = 8'h00;
        page_word = 16'h0000;
        err_count = 0;
        cmp_count = 0;
        repeat (3) @(posedge clk);
        #1 reset_n = 1'b1;
        settle();
        receive_error_pin = 1'b0;
        t_reset();
        t_advert();
        t_pages();
        t_power();
        t_irq();
        t_misc();
        end_of_test();
    end
    // Hang guard.
    initial begin
        #2000000;
        err_count++;
        end_of_test();
    end
endmodule // testbench

bind pacfg_regs pacfg_regs_props u_props (.*);
